// ==== verilog/ahbdw_defines.svh ====
// Constants for the bus data-width adapter.
// Assumes inclusion by bare name from the adapter package and modules.
`ifndef AHBDW_DEFINES_SVH
`define AHBDW_DEFINES_SVH

// =====================================================================
// Widths
`define AHBDW_BUS_W_DEF 64
`define AHBDW_NATIVE_W_DEF 32
`define AHBDW_ADDR_W 32
`define AHBDW_WIDTH_MIN 8
`define AHBDW_WIDTH_MAX 1024
`define AHBDW_WIDTH_PREF_MIN 32
`define AHBDW_WIDTH_PREF_MAX 256

// =====================================================================
// Transfer type and response codes
`define AHBDW_TRANS_IDLE 2'h0
`define AHBDW_TRANS_BUSY 2'h1
`define AHBDW_TRANS_NONSEQ 2'h2
`define AHBDW_TRANS_SEQ 2'h3
`define AHBDW_RESP_OKAY 2'h0
`define AHBDW_RESP_ERROR 2'h1

// =====================================================================
// Reset values
`define AHBDW_HOLD_RESET 1'h0

`endif

// ==== verilog/ahbdw_pkg.sv ====
// Types shared by the bus data-width adapter.
// Assumes ahbdw_defines.svh is on the include path.
`include "ahbdw_defines.svh"

package ahbdw_pkg;

  // =====================================================================
  // Error response sequencing
  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_FIRST,
    ERR_SECOND
  } ahbdw_err_state_t;

  typedef logic [1:0] ahbdw_trans_t;
  typedef logic [1:0] ahbdw_resp_t;
  typedef logic [2:0] ahbdw_size_t;

endpackage : ahbdw_pkg

// ==== verilog/ahbdw_lane_steer.sv ====
// Byte-lane steering between a wide shared bus and a narrow native port.
// Assumes the lane index is the one captured in the address phase.
`timescale 1ns/10ps

`include "ahbdw_defines.svh"

module ahbdw_lane_steer
  import ahbdw_pkg::*;
#(
  parameter int BUS_W = `AHBDW_BUS_W_DEF,
  parameter int NATIVE_W = `AHBDW_NATIVE_W_DEF,
  parameter int LANE_BITS = 1
) (
  input wire logic [BUS_W-1:0] wide_wdata,
  input wire logic [LANE_BITS-1:0] lane,
  input wire logic lane_hold_mode,
  input wire logic [NATIVE_W-1:0] narrow_rdata,
  input wire logic [BUS_W-1:0] held_rdata,
  output logic [NATIVE_W-1:0] narrow_wdata,
  output logic [BUS_W-1:0] wide_rdata
);

  localparam int LANES = BUS_W / NATIVE_W;

  // =====================================================================
  // Write side: pick the addressed lane only
  assign narrow_wdata = wide_wdata[lane*NATIVE_W +: NATIVE_W];

  // =====================================================================
  // Read side: replicate, or drive only the addressed lane
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign wide_rdata[i*NATIVE_W +: NATIVE_W] =
      (!lane_hold_mode || (lane == LANE_BITS'(i))) ? narrow_rdata
                                                   : held_rdata[i*NATIVE_W +: NATIVE_W];
  end

endmodule : ahbdw_lane_steer

// ==== verilog/ahbdw_adapter.sv ====
// Wrapper that puts a narrow native slave on a wider shared system bus.
// Assumes the native slave is a standard pipelined bus slave, one clock.
//
// Functional notes
// - The shared data width is one of 8 to 1024 bits in powers of two, agreed by all modules.
// - A data width of 32 to 256 bits is preferred, as guidance only.
// - The receiver of data picks it from the byte lane of the transfer; no replication needed.
// - The native slave is adapted by outside logic only, its own design untouched.
// - Narrow read data may be copied onto every native-width lane of the wide bus.
// - Alternatively only the addressed lane toggles while the others hold their value.
// - Transfers wider than the native port are refused with the ERROR response.
// - The slave side acts on a transfer only while its decoder select is high.
// - Reset leaves the block idle, and masters show IDLE transfers during it.
`timescale 1ns/10ps

`include "ahbdw_defines.svh"

module ahbdw_adapter
  import ahbdw_pkg::*;
#(
  parameter int BUS_W = `AHBDW_BUS_W_DEF,
  parameter int NATIVE_W = `AHBDW_NATIVE_W_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic lane_hold_mode,
  input wire logic hsel,
  input wire logic [`AHBDW_ADDR_W-1:0] haddr,
  input wire ahbdw_trans_t htrans,
  input wire logic hwrite,
  input wire ahbdw_size_t hsize,
  input wire logic [2:0] hburst,
  input wire logic hready_in,
  input wire logic [BUS_W-1:0] hwdata,
  output logic [BUS_W-1:0] hrdata,
  output logic hready_out,
  output ahbdw_resp_t hresp,
  output logic native_hsel,
  output logic [`AHBDW_ADDR_W-1:0] native_haddr,
  output ahbdw_trans_t native_htrans,
  output logic native_hwrite,
  output ahbdw_size_t native_hsize,
  output logic [2:0] native_hburst,
  output logic native_hready_in,
  output logic [NATIVE_W-1:0] native_hwdata,
  input wire logic [NATIVE_W-1:0] native_hrdata,
  input wire logic native_hready_out,
  input wire ahbdw_resp_t native_hresp
);

  // =====================================================================
  // Geometry
  localparam int LANES = BUS_W / NATIVE_W;
  localparam int BYTE_LO = $clog2(NATIVE_W / 8);
  localparam int LANE_BITS = (LANES > 1) ? $clog2(LANES) : 1;
  localparam ahbdw_size_t NATIVE_SIZE = ahbdw_size_t'(BYTE_LO);
  localparam bit BUS_OK = (BUS_W >= `AHBDW_WIDTH_MIN) && (BUS_W <= `AHBDW_WIDTH_MAX)
                          && ((BUS_W & (BUS_W - 1)) == 0);
  localparam bit NATIVE_OK = (NATIVE_W >= `AHBDW_WIDTH_MIN) && (NATIVE_W <= BUS_W)
                             && ((NATIVE_W & (NATIVE_W - 1)) == 0);

  typedef struct packed {
    logic dphase;
    logic [LANE_BITS-1:0] lane;
    ahbdw_err_state_t err;
    logic [BUS_W-1:0] held;
  } ahbdw_state_t;

  ahbdw_state_t s_reg;
  ahbdw_state_t s_next;
  logic accept;
  logic oversize;
  logic [LANE_BITS-1:0] addr_lane;
  logic [BUS_W-1:0] wide_rdata;

  // =====================================================================
  // Address phase decode
  assign accept = hsel && htrans[1] && hready_in;
  assign oversize = (hsize > NATIVE_SIZE);
  assign addr_lane = (LANES > 1) ? haddr[BYTE_LO +: LANE_BITS] : '0;

  // =====================================================================
  // Native side: control forwarded as sampled, oversize hidden
  assign native_hsel = hsel && !(htrans[1] && oversize);
  assign native_haddr = haddr;
  assign native_htrans = htrans;
  assign native_hwrite = hwrite;
  assign native_hsize = hsize;
  assign native_hburst = hburst;
  assign native_hready_in = hready_in;

  ahbdw_lane_steer #(
    .BUS_W(BUS_W),
    .NATIVE_W(NATIVE_W),
    .LANE_BITS(LANE_BITS)
  ) u_steer (
    .wide_wdata(hwdata),
    .lane(s_reg.lane),
    .lane_hold_mode(lane_hold_mode),
    .narrow_rdata(native_hrdata),
    .held_rdata(s_reg.held),
    .narrow_wdata(native_hwdata),
    .wide_rdata(wide_rdata)
  );

  // Hold mode freezes every lane outside a native data phase
  assign hrdata = (lane_hold_mode && !s_reg.dphase) ? s_reg.held : wide_rdata;

  // =====================================================================
  // Response: own ERROR sequence or native pass-through
  always_comb begin
    unique case (s_reg.err)
      ERR_FIRST: begin
        hready_out = 1'h0;
        hresp = `AHBDW_RESP_ERROR;
      end
      ERR_SECOND: begin
        hready_out = 1'h1;
        hresp = `AHBDW_RESP_ERROR;
      end
      ERR_NONE: begin
        hready_out = s_reg.dphase ? native_hready_out : 1'h1;
        hresp = s_reg.dphase ? native_hresp : `AHBDW_RESP_OKAY;
      end
      default: begin
        hready_out = 1'h1;
        hresp = `AHBDW_RESP_OKAY;
      end
    endcase
  end

  // =====================================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    if (hready_in) begin
      s_next.dphase = accept && !oversize;
      if (accept) begin
        s_next.lane = addr_lane;
      end
    end
    unique case (s_reg.err)
      ERR_NONE: begin
        if (accept && oversize) begin
          s_next.err = ERR_FIRST;
        end
      end
      ERR_FIRST: begin
        s_next.err = ERR_SECOND;
      end
      ERR_SECOND: begin
        s_next.err = (accept && oversize) ? ERR_FIRST : ERR_NONE;
      end
      default: begin
        s_next.err = ERR_NONE;
      end
    endcase
    if (s_reg.dphase && native_hready_out) begin
      s_next.held = wide_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // =====================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic [NATIVE_W-1:0] sel_rlane;
  logic [NATIVE_W-1:0] sel_wlane;
  assign sel_rlane = hrdata[s_reg.lane*NATIVE_W +: NATIVE_W];
  assign sel_wlane = hwdata[s_reg.lane*NATIVE_W +: NATIVE_W];
  // Marks the lane of the current data phase
  logic [BUS_W-1:0] lane_mask;
  assign lane_mask = BUS_W'({NATIVE_W{1'h1}}) << (s_reg.lane * NATIVE_W);

  chk_width_legal: assert property (BUS_OK && NATIVE_OK)
    else $error("illegal data width");
  chk_wr_lane: assert property (s_reg.dphase |-> native_hwdata == sel_wlane)
    else $error("write lane not steered");
  chk_rd_lane: assert property (s_reg.dphase |-> sel_rlane == native_hrdata)
    else $error("read lane not driven");
  chk_rd_replicate: assert property (!lane_hold_mode |-> hrdata == {LANES{native_hrdata}})
    else $error("read data not replicated");
  chk_rd_hold: assert property (lane_hold_mode && !s_reg.dphase |-> hrdata == s_reg.held)
    else $error("idle read lanes toggled");
  chk_err_two: assert property (
    accept && oversize |=> (!hready_out && hresp == `AHBDW_RESP_ERROR)
                           ##1 (hready_out && hresp == `AHBDW_RESP_ERROR))
    else $error("oversize transfer not refused");
  chk_sel_gate: assert property (!hsel || (htrans[1] && oversize) |-> !native_hsel)
    else $error("native slave selected wrongly");
  chk_lane_cap: assert property (
    accept && !oversize |=> s_reg.dphase && s_reg.lane == $past(addr_lane))
    else $error("lane not captured");
  chk_ready_pass: assert property (
    s_reg.dphase |-> hready_out == native_hready_out && hresp == native_hresp)
    else $error("ready or response altered");
  chk_hold_other: assert property (
    lane_hold_mode && s_reg.dphase |-> ((hrdata ^ s_reg.held) & ~lane_mask) == '0)
    else $error("unaddressed read lane toggled");
  chk_reset_idle: assert property ($past(reset) |-> s_reg.err == ERR_NONE && hready_out)
    else $error("not idle after reset");

  cov_err_seq: cover property (accept && oversize ##2 s_reg.err == ERR_SECOND);
  cov_hold_read: cover property (lane_hold_mode && s_reg.dphase && native_hready_out && !hwrite);
  cov_repl_read: cover property (!lane_hold_mode && s_reg.dphase && native_hready_out);
  cov_pref_width: cover property (BUS_W >= `AHBDW_WIDTH_PREF_MIN
                                  && BUS_W <= `AHBDW_WIDTH_PREF_MAX);

endmodule : ahbdw_adapter

// ==== tb/ahbdw_slave_model.sv ====
// Native 32-bit slave model behind the adapter.
// Assumes one clock and the adapter's synchronous active-high reset.
`timescale 1ns/10ps

`include "ahbdw_defines.svh"

module ahbdw_slave_model
  import ahbdw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic waits,
  input wire logic hsel,
  input wire ahbdw_trans_t htrans,
  input wire logic hwrite,
  input wire logic hready_in,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready_out,
  output ahbdw_resp_t hresp
);
  logic dp_reg, wr_reg, wt_reg;
  logic [31:0] mem_reg;

  assign hready_out = !(dp_reg && wt_reg);
  assign hresp = `AHBDW_RESP_OKAY;
  // Outside a read data phase the bus is not ours: show a changing value
  assign hrdata = (dp_reg && !wr_reg) ? mem_reg : ~mem_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      dp_reg <= 1'h0;
      wt_reg <= 1'h0;
      wr_reg <= 1'h0;
      mem_reg <= 32'h0;
    end else if (hready_out) begin
      if (dp_reg && wr_reg) begin
        mem_reg <= hwdata;
      end
      dp_reg <= hsel && htrans[1] && hready_in;
      wt_reg <= waits;
      wr_reg <= hwrite;
    end else begin
      wt_reg <= 1'h0;
    end
  end
endmodule : ahbdw_slave_model

// ==== tb/ahbdw_adapter_tb.sv ====
// Testbench for the data-width adapter, 64-bit bus over a 32-bit slave.
// Assumes the slave model file; bus ready loops back from the adapter.
`timescale 1ns/10ps

`include "ahbdw_defines.svh"

module ahbdw_adapter_tb
  import ahbdw_pkg::*;
;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic lane_hold_mode = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic waits = 1'h0;
  logic [31:0] haddr = 32'h0;
  ahbdw_trans_t htrans = `AHBDW_TRANS_IDLE;
  ahbdw_size_t hsize = 3'h2;
  logic [2:0] hburst = 3'h0;
  logic [63:0] hwdata = 64'h0;
  logic [63:0] hrdata, rd;
  logic hready_out, hready_in, n_sel, n_wr, n_rdy_in, n_rdy, ns;
  ahbdw_trans_t n_trans;
  ahbdw_resp_t hresp, n_resp, rs;
  logic [31:0] n_wdata, n_rdata, lo;
  logic [31:0] n_addr;
  ahbdw_size_t n_size;
  logic [2:0] n_burst;
  int fails = 0;
  int num_checks = 0;
  int nw;

  assign hready_in = hready_out;
  always #25 ref_clk = ~ref_clk;

  ahbdw_adapter #(.BUS_W(64), .NATIVE_W(32)) i_ahbdw_adapter (
    .ref_clk(ref_clk), .reset(reset), .lane_hold_mode(lane_hold_mode), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
    .hready_in(hready_in), .hwdata(hwdata), .hrdata(hrdata), .hready_out(hready_out),
    .hresp(hresp), .native_hsel(n_sel), .native_haddr(n_addr), .native_htrans(n_trans),
    .native_hwrite(n_wr), .native_hsize(n_size), .native_hburst(n_burst),
    .native_hready_in(n_rdy_in),
    .native_hwdata(n_wdata), .native_hrdata(n_rdata), .native_hready_out(n_rdy),
    .native_hresp(n_resp));

  ahbdw_slave_model i_ahbdw_slave_model (
    .ref_clk(ref_clk), .reset(reset), .waits(waits), .hsel(n_sel), .htrans(n_trans),
    .hwrite(n_wr), .hready_in(n_rdy_in), .hwdata(n_wdata), .hrdata(n_rdata),
    .hready_out(n_rdy), .hresp(n_resp));

  task check(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : check

  // One transfer: address phase, then data phase until ready
  task automatic xfer(input logic [31:0] a, input logic w, input ahbdw_size_t s,
                      input logic [63:0] wd);
    nw = 0;
    @(posedge ref_clk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= `AHBDW_TRANS_NONSEQ;
    hwrite <= w;
    hsize <= s;
    #1;
    ns = n_sel;
    check(n_addr === a && n_size === s && n_wr === w, "control forwarded");
    check(n_burst === hburst && n_trans === `AHBDW_TRANS_NONSEQ, "type forwarded");
    check(n_rdy_in === hready_in, "ready forwarded");
    @(posedge ref_clk);
    hsel <= 1'h0;
    htrans <= `AHBDW_TRANS_IDLE;
    hwdata <= wd;
    #1;
    while (hready_out !== 1'h1 && nw < 20) begin
      nw++;
      @(posedge ref_clk);
      #1;
    end
    rd = hrdata;
    rs = hresp;
  endtask : xfer

  task t_lanes;
    logic [31:0] v;
    for (int l = 0; l < 2; l++) begin
      v = 32'h12345670 + 32'(l);
      xfer(32'(l * 4), 1'h1, 3'h2, l ? {v, ~v} : {~v, v});
      xfer(32'h0, 1'h0, 3'h2, 64'h0);
      check(ns === 1'h1 && rd === {v, v}, "lane write or replicated read");
    end
  endtask : t_lanes

  task t_hold;
    @(posedge ref_clk);
    lane_hold_mode <= 1'h1;
    xfer(32'h4, 1'h1, 3'h2, {2{32'h5555aaaa}});
    @(posedge ref_clk);
    #1;
    lo = hrdata[31:0];
    xfer(32'h4, 1'h0, 3'h2, 64'h0);
    check(rd === {32'h5555aaaa, lo}, "hold mode read");
  endtask : t_hold

  task t_wait;
    @(posedge ref_clk);
    waits <= 1'h1;
    xfer(32'h4, 1'h0, 3'h2, 64'h0);
    waits <= 1'h0;
    check(nw === 1 && rs === `AHBDW_RESP_OKAY && rd[63:32] === 32'h5555aaaa,
          "wait state pass");
  endtask : t_wait

  task t_err;
    xfer(32'h0, 1'h0, 3'h3, 64'h0);
    check(ns === 1'h0 && nw === 1 && rs === `AHBDW_RESP_ERROR, "oversize");
    xfer(32'h0, 1'h0, 3'h2, 64'h0);
    check(ns === 1'h1 && nw === 0 && rs === `AHBDW_RESP_OKAY, "after error");
  endtask : t_err

  task t_desel;
    @(posedge ref_clk);
    htrans <= `AHBDW_TRANS_NONSEQ;
    #1;
    rd = hrdata;
    check(n_sel === 1'h0, "deselected forwarded");
    @(posedge ref_clk);
    htrans <= `AHBDW_TRANS_IDLE;
    #1;
    check(hready_out === 1'h1 && hresp === `AHBDW_RESP_OKAY, "deselected answered");
    check(hrdata === rd, "deselected read lanes moved");
  endtask : t_desel

  task t_reset;
    @(posedge ref_clk);
    reset <= 1'h1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    check(hrdata === 64'h0 && hready_out === 1'h1, "held lanes not cleared");
  endtask : t_reset

  task report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    check(hready_out === 1'h1 && hresp === `AHBDW_RESP_OKAY, "reset state");
    t_lanes();
    t_hold();
    t_wait();
    t_err();
    t_desel();
    t_reset();
    report_and_stop();
  end

  // Tests need under 60 cycles
  initial begin
    #(50 * 400);
    fails++;
    report_and_stop();
  end
endmodule : ahbdw_adapter_tb
